/* File: instr_decode_pkg.sv */
// shared constants and types for the instruction word decoder
package instr_decode_pkg;
	// word geometry
	localparam int WORD_W   = 24;           // program word width
	localparam int OPC_W    = 8;            // opcode field width
	localparam int OPC_LSB  = 16;           // opcode sits in the top byte
	localparam int OPND_W   = 16;           // operand area below the opcode
	localparam logic [7:0] OPC_NOP = 8'h00; // all-zero top byte

	// opcode groups, taken from the upper nibble of the opcode
	localparam logic [3:0] GRP_NOP    = 4'h0;
	localparam logic [3:0] GRP_WORKING_REG_ZERO   = 4'h1;
	localparam logic [3:0] GRP_FILE   = 4'h2;
	localparam logic [3:0] GRP_BIT    = 4'h3;
	localparam logic [3:0] GRP_LIT    = 4'h4;
	localparam logic [3:0] GRP_MAC    = 4'h5;
	localparam logic [3:0] GRP_DSP    = 4'h6;
	localparam logic [3:0] GRP_BRANCH = 4'h7;
	localparam logic [3:0] GRP_SKIP   = 4'h8;
	localparam logic [3:0] GRP_JUMP   = 4'h9;
	localparam logic [3:0] GRP_TBLRD  = 4'ha;
	localparam logic [3:0] GRP_DJUMP  = 4'hb;
	localparam logic [3:0] GRP_DCALL  = 4'hc;
	localparam logic [3:0] GRP_DMOVE  = 4'hd;

	// operand field positions (low bit of each field in the operand area)
	localparam int F_SRC_REG = 0, F_SRC_MODE = 4, F_DST_REG = 7, F_DST_MODE = 11, F_BYTE = 15;
	localparam int F_FADDR = 0, F_FADDR_W = 13, F_WORKING_REG_ZERO_DST = 13;
	localparam int F_BIT_BASE = 7, F_BIT_FROM_REG = 11, F_BIT_LIT = 12;
	localparam int F_LIT = 0, F_LIT_W = 10, F_LDST_REG = 10, F_LDST_MODE = 14;
	localparam int F_PAIR = 0, F_XPF = 3, F_YPF = 7, F_XD = 11, F_YD = 13;
	localparam int F_SHIFT_FROM_REG = 7, F_SHIFT = 8, F_SHIFT_W = 6;
	localparam int F_AWB = 1;               // opcode bits holding the write-back code

	// accumulator write-back codes
	localparam logic [1:0] AWB_NONE    = 2'h0;
	localparam logic [1:0] AWB_DIRECT  = 2'h1; // result into the write-back register
	localparam logic [1:0] AWB_POSTINC = 2'h2; // result to memory it points at, then +2
	localparam logic [3:0] AWB_REG     = 4'hd; // working register 13
	localparam logic [3:0] AWB_STEP    = 4'h2; // post-increment amount
	localparam logic [3:0] MULT_BASE   = 4'h4; // multiply pairs use registers 4..7
	localparam logic [2:0] PAIR_LAST   = 3'h5; // six legal pair codes

	// decoded instruction classes
	typedef enum logic [3:0] {
		CL_NOP, CL_WORKING_REG_ZERO, CL_FILE, CL_BIT, CL_LIT, CL_MAC, CL_DSP, CL_BRANCH,
		CL_SKIP, CL_JUMP, CL_TBLRD, CL_DJUMP, CL_DCALL, CL_DMOVE
	} instr_class_t;

	// sequencer states
	typedef enum logic [2:0] {ST_DECODE, ST_SECOND, ST_STALL, ST_FLUSH, ST_FLUSH_TAIL} seq_state_t;
endpackage : instr_decode_pkg

/* File: instr_decoder.sv */
// instruction word decoder with cycle sequencing for the 24-bit core
// Contract
// - 24-bit word, 8-bit opcode plus operands
// - only three instructions use two words
// - orphan second word (zero top) runs NOP
// - double-word instructions take two cycles
// - taken test, PC change, table read: extra
// - extra cycles are side-effect-free NOPs
// - taken skip: two or three cycles
// - double-word moves take two cycles
// - register ops: base, source, destination operands
// - file ops: address, file or register zero
// - bit number from literal or base register
// - literal ops write only to distinct destination
// - MAC: accumulator, pair, prefetches, write-back
// - other DSP: accumulator, operand, shift amount
// - write-back: register 13 or [13]+=2
// - multiply pairs: two distinct registers from 4..7
`timescale 1ns/10ps
module instr_decoder
	import instr_decode_pkg::*;
(
	input  wire logic                         clk,                       // core instruction clock
	input  wire logic                         rst,                       // async reset, active high
	input  wire logic                         instr_valid,               // fetch offers a word
	input  wire logic [instr_decode_pkg::WORD_W-1:0] instr_word,         // fetched program word
	input  wire logic                         cond_true,                 // condition of offered word holds
	input  wire logic                         program_space_visibility_read, // operand hits program space
	output logic                              instr_ready,               // a word can be taken this cycle
	output logic                              exec_valid,                // one instruction executes
	output logic                              nop_cycle,                 // an empty cycle was spent
	output instr_decode_pkg::instr_class_t    instr_class,               // class of executing instruction
	output logic [instr_decode_pkg::OPC_W-1:0] opcode,                   // opcode byte
	output logic [3:0]                        base_operand_reg,          // first source register
	output logic [3:0]                        source_operand_reg,        // second source register
	output logic [2:0]                        source_mode,               // source address modifier
	output logic [3:0]                        dest_operand_reg,          // destination register
	output logic [2:0]                        dest_mode,                 // destination address modifier
	output logic                              byte_mode,                 // byte rather than word
	output logic [12:0]                       file_addr,                 // file register address
	output logic                              dest_is_working_reg_zero,  // file result to register zero
	output logic [3:0]                        bit_select,                // literal bit number
	output logic                              bit_from_base_reg,         // bit number held in base reg
	output logic [15:0]                       literal_value,             // literal operand
	output logic                              write_result,              // literal result is written
	output logic                              accum_sel,                 // 0 selects A, 1 selects B
	output logic [3:0]                        mult_reg_x,                // first multiply register
	output logic [3:0]                        mult_reg_y,                // second multiply register
	output logic                              mult_pair_bad,             // pair code out of range
	output logic [3:0]                        x_prefetch,                // X prefetch address code
	output logic [3:0]                        y_prefetch,                // Y prefetch address code
	output logic [3:0]                        x_dest_reg,                // X prefetch destination
	output logic [3:0]                        y_dest_reg,                // Y prefetch destination
	output logic [1:0]                        accum_writeback_dest,      // write-back code
	output logic [3:0]                        awb_reg,                   // write-back register number
	output logic [3:0]                        awb_step,                  // write-back post-increment
	output logic                              shift_from_reg,            // shift held in a register
	output logic [3:0]                        shift_amount_reg,          // register giving the shift
	output logic [5:0]                        shift_literal,             // signed literal shift
	output logic [15:0]                       second_word                // operand word of double
);
	import instr_decode_pkg::*;

	seq_state_t   state_reg, state_next;       // sequencer state
	logic         exec_next, nop_next;         // pulse next values
	instr_class_t cls_in;                      // class of offered word
	logic         take;                        // word handshake
	logic [7:0]   opc_in;                      // top byte of offered word
	logic [15:0]  opnd;                        // operand area of offered word
	logic         is_double;                   // offered word opens a double

	// classify by opcode group; unknown groups decode as NOP
	function automatic instr_class_t classify(input logic [7:0] op);
		instr_class_t c;
		c = CL_NOP;
		if (op == OPC_NOP) c = CL_NOP;
		else if (op[7:4] == GRP_WORKING_REG_ZERO) c = CL_WORKING_REG_ZERO;
		else if (op[7:4] == GRP_FILE) c = CL_FILE;
		else if (op[7:4] == GRP_BIT) c = CL_BIT;
		else if (op[7:4] == GRP_LIT) c = CL_LIT;
		else if (op[7:4] == GRP_MAC) c = CL_MAC;
		else if (op[7:4] == GRP_DSP) c = CL_DSP;
		else if (op[7:4] == GRP_BRANCH) c = CL_BRANCH;
		else if (op[7:4] == GRP_SKIP) c = CL_SKIP;
		else if (op[7:4] == GRP_JUMP) c = CL_JUMP;
		else if (op[7:4] == GRP_TBLRD) c = CL_TBLRD;
		else if (op[7:4] == GRP_DJUMP) c = CL_DJUMP;
		else if (op[7:4] == GRP_DCALL) c = CL_DCALL;
		else if (op[7:4] == GRP_DMOVE) c = CL_DMOVE;
		return c;
	endfunction : classify

	// exactly three classes span two words
	function automatic logic two_words(input instr_class_t c);
		return (c == CL_DJUMP) || (c == CL_DCALL) || (c == CL_DMOVE);
	endfunction : two_words

	// split the word; the opcode always comes from the top byte
	assign opc_in      = instr_word[OPC_LSB +: OPC_W];
	assign opnd        = instr_word[OPND_W-1:0];
	assign cls_in      = classify(opc_in);
	assign is_double   = two_words(cls_in);
	assign instr_ready = (state_reg != ST_STALL); // stall cycles accept nothing
	assign take        = instr_valid && instr_ready;
	assign awb_reg     = AWB_REG;
	assign awb_step    = AWB_STEP;

	// sequencer next state and the execute / empty-cycle pulses
	always_comb begin
		state_next = state_reg;
		exec_next  = 1'b0;
		nop_next   = 1'b0;
		case (state_reg)
			ST_DECODE: begin
				if (take) begin
					if (is_double) begin
						state_next = ST_SECOND;
					end else if (cls_in == CL_NOP) begin
						nop_next = 1'b1;
					end else begin
						exec_next = 1'b1;
						if (cls_in == CL_SKIP && cond_true) begin
							state_next = ST_FLUSH;
						end else if ((cls_in == CL_BRANCH && cond_true) || cls_in == CL_JUMP ||
							cls_in == CL_TBLRD || program_space_visibility_read) begin
							state_next = ST_STALL;
						end
					end
				end
			end
			ST_SECOND: begin
				if (take) begin
					exec_next  = 1'b1;
					state_next = ST_DECODE;
				end
			end
			ST_STALL: begin
				nop_next   = 1'b1;
				state_next = ST_DECODE;
			end
			ST_FLUSH: begin
				// skipped word is swallowed; a double needs its tail swallowed too
				if (take) begin
					nop_next   = 1'b1;
					state_next = is_double ? ST_FLUSH_TAIL : ST_DECODE;
				end
			end
			ST_FLUSH_TAIL: begin
				if (take) begin
					nop_next   = 1'b1;
					state_next = ST_DECODE;
				end
			end
			default: state_next = ST_DECODE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg  <= ST_DECODE;
			exec_valid <= 1'b0;
			nop_cycle  <= 1'b0;
		end else begin
			state_reg  <= state_next;
			exec_valid <= exec_next;
			nop_cycle  <= nop_next;
		end
	end

	// operand field next values
	instr_class_t cls_next;
	logic [7:0]   opc_next;
	logic [3:0]   base_next, src_next, dst_next, bitsel_next, mx_next, my_next;
	logic [3:0]   xpf_next, ypf_next, xd_next, yd_next, shreg_next;
	logic [2:0]   smode_next, dmode_next;
	logic [12:0]  faddr_next;
	logic [15:0]  lit_next, second_next;
	logic [1:0]   awb_next;
	logic [5:0]   shlit_next;
	logic         byte_next, wz_next, bfr_next, wr_next, acc_next, bad_next, sfr_next;

	// a stalled or swallowed word leaves the fields alone, so NOP cycles change nothing
	always_comb begin
		// enum kept out of concatenations so the assignment stays type-safe
		cls_next = instr_class;
		opc_next = opcode;
		{base_next, src_next, dst_next, bitsel_next} = {base_operand_reg, source_operand_reg,
			dest_operand_reg, bit_select};
		{mx_next, my_next, xpf_next, ypf_next} = {mult_reg_x, mult_reg_y, x_prefetch, y_prefetch};
		{xd_next, yd_next, shreg_next} = {x_dest_reg, y_dest_reg, shift_amount_reg};
		{smode_next, dmode_next, faddr_next} = {source_mode, dest_mode, file_addr};
		{lit_next, second_next, awb_next, shlit_next} = {literal_value, second_word,
			accum_writeback_dest, shift_literal};
		{byte_next, wz_next, bfr_next, wr_next} = {byte_mode, dest_is_working_reg_zero,
			bit_from_base_reg, write_result};
		{acc_next, bad_next, sfr_next} = {accum_sel, mult_pair_bad, shift_from_reg};
		if (take && state_reg == ST_SECOND) begin
			second_next = opnd; // top byte of this word is zero by construction
		end else if (take && state_reg == ST_DECODE && cls_in != CL_NOP) begin
			cls_next   = cls_in;
			opc_next   = opc_in;
			base_next  = opc_in[3:0];
			src_next   = opnd[F_SRC_REG +: 4];
			smode_next = opnd[F_SRC_MODE +: 3];
			dst_next   = opnd[F_DST_REG +: 4];
			dmode_next = opnd[F_DST_MODE +: 3];
			byte_next  = opnd[F_BYTE];
			faddr_next = opnd[F_FADDR +: F_FADDR_W];
			wz_next    = opnd[F_WORKING_REG_ZERO_DST];
			bfr_next   = opnd[F_BIT_FROM_REG];
			bitsel_next = opnd[F_BIT_LIT +: 4];
			lit_next   = 16'(opnd[F_LIT +: F_LIT_W]);
			wr_next    = 1'b1;
			acc_next   = opc_in[0];
			mx_next    = 4'h0;
			my_next    = 4'h0;
			bad_next   = 1'b0;
			xpf_next   = opnd[F_XPF +: 4];
			ypf_next   = opnd[F_YPF +: 4];
			xd_next    = MULT_BASE | 4'(opnd[F_XD +: 2]);
			yd_next    = MULT_BASE | 4'(opnd[F_YD +: 2]);
			awb_next   = opc_in[F_AWB +: 2];
			sfr_next   = opnd[F_SHIFT_FROM_REG];
			shreg_next = opnd[F_SHIFT +: 4];
			shlit_next = opnd[F_SHIFT +: F_SHIFT_W];
			case (cls_in)
				CL_BIT: begin
					// file form carries the bit number in the opcode, never in a register
					if (opc_in[3]) begin
						bitsel_next = opc_in[3:0] & 4'h7;
						bfr_next    = 1'b0;
					end else begin
						base_next = opnd[F_BIT_BASE +: 4];
					end
				end
				CL_LIT: begin
					dst_next   = opnd[F_LDST_REG +: 4];
					dmode_next = {1'b0, opnd[F_LDST_MODE +: 2]};
					// same register, no modifier: the base already is the destination
					wr_next    = (opnd[F_LDST_REG +: 4] != opc_in[3:0]) ||
						(opnd[F_LDST_MODE +: 2] != 2'h0);
				end
				CL_MAC: begin
					// codes 0..5 map to 4*5,4*6,4*7,5*6,5*7,6*7
					bad_next = opnd[F_PAIR +: 3] > PAIR_LAST;
					case (opnd[F_PAIR +: 3])
						3'h0: begin mx_next = 4'h4; my_next = 4'h5; end
						3'h1: begin mx_next = 4'h4; my_next = 4'h6; end
						3'h2: begin mx_next = 4'h4; my_next = 4'h7; end
						3'h3: begin mx_next = 4'h5; my_next = 4'h6; end
						3'h4: begin mx_next = 4'h5; my_next = 4'h7; end
						3'h5: begin mx_next = 4'h6; my_next = 4'h7; end
						default: begin mx_next = 4'h0; my_next = 4'h0; end
					endcase
					if (opc_in[F_AWB +: 2] == 2'h3) awb_next = AWB_NONE; // unused code writes nothing
				end
				default: ;
			endcase
		end
	end

	// operand field registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr_class <= CL_NOP;
			opcode      <= OPC_NOP;
			{base_operand_reg, source_operand_reg, dest_operand_reg, bit_select} <= 16'h0000;
			{mult_reg_x, mult_reg_y, x_prefetch, y_prefetch} <= 16'h0000;
			{x_dest_reg, y_dest_reg, shift_amount_reg} <= 12'h000;
			{source_mode, dest_mode, file_addr} <= 19'h00000;
			{literal_value, second_word, accum_writeback_dest, shift_literal} <= 40'h0000000000;
			{byte_mode, dest_is_working_reg_zero, bit_from_base_reg, write_result} <= 4'h0;
			{accum_sel, mult_pair_bad, shift_from_reg} <= 3'h0;
		end else begin
			instr_class <= cls_next;
			opcode      <= opc_next;
			{base_operand_reg, source_operand_reg, dest_operand_reg, bit_select} <=
				{base_next, src_next, dst_next, bitsel_next};
			{mult_reg_x, mult_reg_y, x_prefetch, y_prefetch} <= {mx_next, my_next, xpf_next, ypf_next};
			{x_dest_reg, y_dest_reg, shift_amount_reg} <= {xd_next, yd_next, shreg_next};
			{source_mode, dest_mode, file_addr} <= {smode_next, dmode_next, faddr_next};
			{literal_value, second_word, accum_writeback_dest, shift_literal} <=
				{lit_next, second_next, awb_next, shlit_next};
			{byte_mode, dest_is_working_reg_zero, bit_from_base_reg, write_result} <=
				{byte_next, wz_next, bfr_next, wr_next};
			{accum_sel, mult_pair_bad, shift_from_reg} <= {acc_next, bad_next, sfr_next};
		end
	end

	// checks on the sequencer and the decoded fields
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// unused groups and nibble-zero opcodes run as nop, so key on the class, not the raw byte
	chk_opcode_top_byte: assert property (take && state_reg == ST_DECODE && !is_double && cls_in != CL_NOP
		|=> exec_valid && opcode == $past(instr_word[23:16])) else $error("opcode not from top byte");
	chk_orphan_nop: assert property (take && state_reg == ST_DECODE && opc_in == OPC_NOP
		|=> nop_cycle && !exec_valid) else $error("zero top byte did not run as nop");
	chk_double_two: assert property (take && state_reg == ST_DECODE && is_double
		|=> !exec_valid && state_reg == ST_SECOND) else $error("double word executed early");
	chk_double_end: assert property (take && state_reg == ST_SECOND
		|=> exec_valid && second_word == $past(instr_word[15:0])) else $error("second word lost");
	chk_taken_stall: assert property (take && state_reg == ST_DECODE && cls_in == CL_BRANCH && cond_true
		|=> !instr_ready ##1 instr_ready && nop_cycle) else $error("taken branch lacks one nop");
	// the opcode legitimately changes on entry to the stall, so compare across the stall cycle only
	chk_stall_quiet: assert property (state_reg == ST_STALL |=> nop_cycle && !exec_valid && $stable(opcode))
		else $error("nop cycle changed state");
	chk_skip_flush: assert property (state_reg == ST_FLUSH && take && is_double
		|=> nop_cycle && state_reg == ST_FLUSH_TAIL) else $error("skipped double not swallowed");
	chk_lit_write: assert property (exec_valid && instr_class == CL_LIT |-> write_result ==
		(dest_operand_reg != base_operand_reg || dest_mode != 3'h0)) else $error("literal write wrong");
	chk_mult_pair: assert property (exec_valid && instr_class == CL_MAC && !mult_pair_bad
		|-> mult_reg_x >= 4'h4 && mult_reg_x < mult_reg_y && mult_reg_y <= 4'h7)
		else $error("bad multiply pair");
	chk_awb_code: assert property (exec_valid && instr_class == CL_MAC |-> accum_writeback_dest != 2'h3)
		else $error("illegal write-back code");

	cov_double: cover property (state_reg == ST_SECOND && take ##1 exec_valid);
	cov_skip_three: cover property (state_reg == ST_FLUSH && take && is_double ##1 take ##1 nop_cycle);
	cov_branch: cover property (state_reg == ST_STALL ##1 nop_cycle);
	cov_orphan: cover property (nop_cycle && state_reg == ST_DECODE && !exec_valid);
endmodule : instr_decoder

/* File: instruction_format_timing_bench.sv */
// self-checking bench for the instruction word decoder
`timescale 1ns/10ps
module instruction_format_timing_bench;
	import instr_decode_pkg::*;
	logic                clk, rst, instr_valid, cond_true, program_space_visibility_read; // driven inputs
	logic [WORD_W-1:0]   instr_word;                                    // offered program word
	logic                instr_ready, exec_valid, nop_cycle, byte_mode, dest_is_working_reg_zero; // flags
	logic                bit_from_base_reg, write_result, accum_sel, mult_pair_bad, shift_from_reg; // flags
	instr_class_t        instr_class;                                   // decoded class
	logic [OPC_W-1:0]    opcode;                                        // opcode byte
	logic [3:0]          base_operand_reg, source_operand_reg, dest_operand_reg, bit_select, mult_reg_x;
	logic [3:0]          mult_reg_y, x_prefetch, y_prefetch, x_dest_reg, y_dest_reg, awb_reg, awb_step;
	logic [3:0]          shift_amount_reg;                              // shift register number
	logic [2:0]          source_mode, dest_mode;                        // address modifiers
	logic [12:0]         file_addr;                                     // file address
	logic [15:0]         literal_value, second_word;                    // wide fields
	logic [1:0]          accum_writeback_dest;                          // write-back code
	logic [5:0]          shift_literal;                                 // literal shift
	int                  mismatches = 0, n_checks = 0, cycles = 0;      // bookkeeping

	instr_decoder instr_decoder_inst (
		.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word), .cond_true(cond_true),
		.program_space_visibility_read(program_space_visibility_read), .instr_ready(instr_ready),
		.exec_valid(exec_valid), .nop_cycle(nop_cycle), .instr_class(instr_class), .opcode(opcode),
		.base_operand_reg(base_operand_reg), .source_operand_reg(source_operand_reg), .source_mode(source_mode),
		.dest_operand_reg(dest_operand_reg), .dest_mode(dest_mode), .byte_mode(byte_mode), .file_addr(file_addr),
		.dest_is_working_reg_zero(dest_is_working_reg_zero), .bit_select(bit_select),
		.bit_from_base_reg(bit_from_base_reg), .literal_value(literal_value), .write_result(write_result),
		.accum_sel(accum_sel), .mult_reg_x(mult_reg_x), .mult_reg_y(mult_reg_y), .mult_pair_bad(mult_pair_bad),
		.x_prefetch(x_prefetch), .y_prefetch(y_prefetch), .x_dest_reg(x_dest_reg), .y_dest_reg(y_dest_reg),
		.accum_writeback_dest(accum_writeback_dest), .awb_reg(awb_reg), .awb_step(awb_step),
		.shift_from_reg(shift_from_reg), .shift_amount_reg(shift_amount_reg), .shift_literal(shift_literal),
		.second_word(second_word)
	);

	// 50 MHz core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard: the whole run needs well under a hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			wrap_up();
		end
	end

	// verdict and end of run
	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	// compare with case equality so an unknown never matches
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// entered at a falling edge; offers one word, returns at the next falling edge with its answer settled
	task automatic send(input logic [23:0] w, input logic c, input logic p);
		instr_valid = 1'b1;
		instr_word = w;
		cond_true = c;
		program_space_visibility_read = p;
		@(posedge clk);
		@(negedge clk);
	endtask : send

	// one empty fetch cycle
	task automatic idle();
		instr_valid = 1'b0;
		cond_true = 1'b0;
		program_space_visibility_read = 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask : idle

	// register-form operands: base in opcode, source and destination with modifiers
	task automatic t_working_reg_zero();
		send(24'h1a94d3, 1'b0, 1'b0);
		chk("exec_valid", 1, exec_valid);
		chk("opcode", 8'h1a, opcode);
		chk("instr_class", CL_WORKING_REG_ZERO, instr_class);
		chk("base_operand_reg", 4'ha, base_operand_reg);
		chk("source_operand_reg", 4'h3, source_operand_reg);
		chk("source_mode", 3'h5, source_mode);
		chk("dest_operand_reg", 4'h9, dest_operand_reg);
		chk("dest_mode", 3'h2, dest_mode);
		chk("byte_mode", 1, byte_mode);
	endtask : t_working_reg_zero

	// file form: result to the file or to register zero; bit form: literal or register bit number
	task automatic t_file_bit();
		send(24'h203abc, 1'b0, 1'b0);
		chk("file_addr", 13'h1abc, file_addr);
		chk("dest_is_working_reg_zero", 1, dest_is_working_reg_zero);
		send(24'h201abc, 1'b0, 1'b0);
		chk("dest_is_working_reg_zero", 0, dest_is_working_reg_zero);
		send(24'h30b000, 1'b0, 1'b0);
		chk("bit_select", 4'hb, bit_select);
		chk("bit_from_base_reg", 0, bit_from_base_reg);
		send(24'h300b00, 1'b0, 1'b0);
		chk("bit_from_base_reg", 1, bit_from_base_reg);
		chk("base_operand_reg", 4'h6, base_operand_reg);
		send(24'h3d0000, 1'b0, 1'b0);
		chk("bit_select", 4'h5, bit_select);
		chk("bit_from_base_reg", 0, bit_from_base_reg);
	endtask : t_file_bit

	// literal ops skip the write when destination is the base with no modifier; then both DSP shift sources
	task automatic t_lit_dsp();
		send(24'h4517ff, 1'b0, 1'b0);
		chk("literal_value", 16'h03ff, literal_value);
		chk("write_result", 0, write_result);
		send(24'h451bff, 1'b0, 1'b0);
		chk("write_result", 1, write_result);
		send(24'h610c80, 1'b0, 1'b0);
		chk("accum_sel", 1, accum_sel);
		chk("shift_from_reg", 1, shift_from_reg);
		chk("shift_amount_reg", 4'hc, shift_amount_reg);
		send(24'h603a00, 1'b0, 1'b0);
		chk("shift_from_reg", 0, shift_from_reg);
		chk("shift_literal", 6'h3a, shift_literal);
	endtask : t_lit_dsp

	// every pair code, every write-back code and both accumulators, back to back
	task automatic t_mac();
		logic [3:0] px [6] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
		logic [3:0] py [6] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
		for (int i = 0; i < 8; i++) begin
			send({4'h5, 1'b0, i[1:0], i[2], 16'h31c8 | 16'(i)}, 1'b0, 1'b0);
			chk("accum_sel", i[2], accum_sel);
			chk("accum_writeback_dest", (i[1:0] == 2'h3) ? AWB_NONE : i[1:0], accum_writeback_dest);
			chk("mult_pair_bad", i > 5, mult_pair_bad);
			if (i < 6) begin
				chk("mult_reg_x", px[i], mult_reg_x);
				chk("mult_reg_y", py[i], mult_reg_y);
			end
		end
		chk("x_prefetch", 4'h9, x_prefetch);
		chk("y_prefetch", 4'h3, y_prefetch);
		chk("x_dest_reg", 4'h6, x_dest_reg);
		chk("y_dest_reg", 4'h5, y_dest_reg);
		chk("awb_reg", 4'hd, awb_reg);
		chk("awb_step", 4'h2, awb_step);
	endtask : t_mac

	// the three two-word classes, then a lone second word
	task automatic t_double();
		logic [7:0]   dop [3] = '{8'hb0, 8'hc0, 8'hd0};
		instr_class_t dcl [3] = '{CL_DJUMP, CL_DCALL, CL_DMOVE};
		for (int k = 0; k < 3; k++) begin
			send({dop[k], 16'h1234}, 1'b0, 1'b0);
			chk("exec_valid", 0, exec_valid);
			send({8'h00, 16'hbe00 | 16'(k)}, 1'b0, 1'b0);
			chk("exec_valid", 1, exec_valid);
			chk("instr_class", dcl[k], instr_class);
			chk("second_word", 16'hbe00 | 16'(k), second_word);
			idle();
			idle();
		end
		send(24'h005a5a, 1'b0, 1'b0);
		chk("nop_cycle", 1, nop_cycle);
		chk("exec_valid", 0, exec_valid);
		chk("second_word", 16'hbe02, second_word);
	endtask : t_double

	// taken branch, untaken branch, jump, table read and program-space read
	task automatic t_stall();
		logic [7:0] op [5] = '{8'h70, 8'h70, 8'h90, 8'ha0, 8'h10};
		logic       cd [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		logic       ps [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		logic       st [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
		for (int k = 0; k < 5; k++) begin
			send({op[k], 16'h0000}, cd[k], ps[k]);
			chk("exec_valid", 1, exec_valid);
			chk("instr_ready", !st[k], instr_ready);
			idle();
			chk("nop_cycle", st[k], nop_cycle);
			chk("exec_valid", 0, exec_valid);
			chk("instr_ready", 1, instr_ready);
		end
	endtask : t_stall

	// taken skip over a single word, then over a double word
	task automatic t_skip();
		send(24'h800000, 1'b1, 1'b0);
		chk("exec_valid", 1, exec_valid);
		send(24'h1a0000, 1'b0, 1'b0);
		chk("nop_cycle", 1, nop_cycle);
		idle();
		chk("nop_cycle", 0, nop_cycle);
		send(24'h800000, 1'b1, 1'b0);
		send(24'hd01234, 1'b0, 1'b0);
		chk("nop_cycle", 1, nop_cycle);
		send(24'h000777, 1'b0, 1'b0);
		chk("nop_cycle", 1, nop_cycle);
		chk("exec_valid", 0, exec_valid);
		idle();
		chk("nop_cycle", 0, nop_cycle);
	endtask : t_skip

	// reset for twelve cycles, then the scenarios in turn
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = '0;
		cond_true = 1'b0;
		program_space_visibility_read = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk("instr_ready", 1, instr_ready);
		chk("instr_class", CL_NOP, instr_class);
		t_working_reg_zero();
		t_file_bit();
		t_lit_dsp();
		t_mac();
		t_double();
		t_stall();
		t_skip();
		wrap_up();
	end
endmodule : instruction_format_timing_bench
